// file: flsr_defs.vh
// Purpose: Shared constants for the dual-die status register one block
// Assumes: 50 MHz core clock
// Notes: Opcodes without a fixed value elsewhere are plain defaults
`ifndef FLSR_DEFS_VH
`define FLSR_DEFS_VH

`define FLSR_CMD_REGISTER_WRITE 8'h01
`define FLSR_CMD_READ_STATUS_ONE 8'h05
`define FLSR_CMD_READ_STATUS_TWO 8'h07
`define FLSR_CMD_ARM_WRITE 8'h06
`define FLSR_CMD_DISARM_WRITE 8'h04
`define FLSR_CMD_CLEAR_STATUS 8'h30
`define FLSR_CMD_PAGE_PROGRAM 8'h02
`define FLSR_CMD_SECTOR_ERASE 8'hD8
`define FLSR_CMD_WHOLE_ARRAY_ERASE 8'h60
`define FLSR_CMD_ERASE_PAUSE 8'h75
`define FLSR_CMD_PROGRAM_PAUSE 8'h85
`define FLSR_CMD_SOFT_RESET 8'hF0

`define FLSR_BIT_ACTIVE 0
`define FLSR_BIT_ARM 1
`define FLSR_BIT_GUARD_LO 2
`define FLSR_BIT_GUARD_HI 4
`define FLSR_BIT_ERASE_FAIL 5
`define FLSR_BIT_PROG_FAIL 6
`define FLSR_BIT_WRITE_LOCK 7

`define FLSR_RST_GUARD 3'h7
`define FLSR_RST_WRITE_LOCK 1'b0

`define FLSR_CLK_MHZ 50
`define FLSR_REG_WRITE_TIME_US 2
`define FLSR_REG_WRITE_CYC (`FLSR_REG_WRITE_TIME_US * `FLSR_CLK_MHZ)
`define FLSR_TMR_W 8

`define FLSR_SYNC_W 12
// Reset pin, protect pin and chip select idle high, so no false frame edge after reset
`define FLSR_SYNC_INIT 12'hE00

`endif

// file: flsr_sync.v
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs asynchronous to ref_clk_in
// Notes: Output changes only when stages two and three agree
`timescale 1ns/10ps
module flsr_sync #(
  parameter W = 12,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire ref_clk_in,
  input wire rst_in,
  input wire [W-1:0] d_in,
  output reg [W-1:0] q_out
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  integer i;

  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      q_out <= INIT;
    end
    else
    begin
      s1_q <= d_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Stage one is never looked at here, only stages two and three
      for (i = 0; i < W; i = i + 1)
      begin
        if (s2_q[i] == s3_q[i])
        begin
          q_out[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

// file: flsr_status_one.v
// Purpose: Status register one of both dies of a dual-quad serial flash
// Assumes: Mode 0 serial clock, two nibbles per byte, high nibble first
// Notes: Array engine and address handling sit outside this block
`timescale 1ns/10ps
`include "flsr_defs.vh"

// Operation
// - Arm write command sets the write arm latch.
// - Disarm write command clears the latch, blocking later modifying commands.
// - Successful program, register write or erase clears the latch.
// - Register write, program and erase are ignored while the latch is zero.
// - Register write data never loads the write arm latch; its completion clears it.
// - Power cycle, hardware or software reset clears the write arm latch.
// - While busy, only status reads, pauses, clear status and reset are taken.
// - Erase pause only during erase, program pause only during program.
// - A set failure flag keeps the device busy until clear status.
// - Failure flags update only while the operation is active.
// - Program failure or protected target sets the program failure flag.
// - Erase failure or protected sector erase sets the erase failure flag.
// - Whole-array erase meeting a protected sector does not set erase failure.
// - Failure flags are read-only; clear status resets them.
// - Lock set and protect pin low reject register writes.
// - Protect pin high or lock clear lets register writes change guard bits.
// - Guard bits volatile or not by persistence bit; set bits protect array.
// - Whole-array erase runs only when all guard bits are zero.
// - Resets restore volatile bits; nonvolatile bits keep their values.
// - Read with read status one, write with register write.
module flsr_status_one (
  input wire ref_clk_in,
  input wire rst_in,
  input wire sck_in,
  input wire cs_n_in,
  input wire [7:0] io_in,
  input wire wp_n_in,
  input wire hw_reset_n_in,
  input wire guard_persistence_bit_in,
  input wire [1:0] op_done_in,
  input wire [1:0] op_fail_in,
  input wire [1:0] op_prot_in,
  output wire [7:0] io_out,
  output wire [7:0] io_oe_out,
  output wire [1:0] prog_start_out,
  output wire [1:0] sector_erase_start_out,
  output wire [1:0] whole_erase_start_out,
  output wire [1:0] erase_pause_out,
  output wire [1:0] prog_pause_out,
  output wire [5:0] block_guard_out,
  output wire [15:0] status_one_out
);
  localparam [1:0] K_IDLE = 2'h0;
  localparam [1:0] K_REG = 2'h1;
  localparam [1:0] K_PROG = 2'h2;
  localparam [1:0] K_ERASE = 2'h3;
  localparam [`FLSR_TMR_W-1:0] K_WR_CYC = `FLSR_REG_WRITE_CYC;

  wire [11:0] sync_w;
  wire [7:0] io_s = sync_w[7:0];
  wire sck_s = sync_w[8];
  wire cs_n_s = sync_w[9];
  wire wp_n_s = sync_w[10];
  wire hw_reset_n_s = sync_w[11];

  reg sck_d_q;
  reg cs_n_d_q;
  reg [4:0] nib_cnt_q;

  flsr_sync #(
    .W(`FLSR_SYNC_W),
    .INIT(`FLSR_SYNC_INIT)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .d_in({hw_reset_n_in, wp_n_in, cs_n_in, sck_in, io_in}),
    .q_out(sync_w)
  );

  wire sck_rise = sck_s & ~sck_d_q & ~cs_n_s;
  wire sck_fall = ~sck_s & sck_d_q & ~cs_n_s;
  wire frame_end = cs_n_s & ~cs_n_d_q;
  // Only whole bytes count; a trailing odd nibble voids the frame
  wire exec = frame_end & ~nib_cnt_q[0] & (nib_cnt_q != 5'h00);
  wire [3:0] nbytes = nib_cnt_q[4:1];

  // Modifying commands need an idle device and an armed latch
  function may_modify;
    input arm;
    input busy;
    begin
      may_modify = arm & ~busy;
    end
  endfunction

  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      sck_d_q <= 1'b0;
      cs_n_d_q <= 1'b1;
      nib_cnt_q <= 5'h00;
    end
    else
    begin
      sck_d_q <= sck_s;
      cs_n_d_q <= cs_n_s;
      if (cs_n_s)
      begin
        nib_cnt_q <= 5'h00;
      end
      else if (sck_rise && nib_cnt_q != 5'h1F)
      begin
        nib_cnt_q <= nib_cnt_q + 5'h01;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_die
      reg [3:0] hold_q;
      reg [7:0] cmd_q;
      reg [7:0] data_q;
      reg write_arm_latch_q;
      reg operation_active_flag_q;
      reg prog_fail_q;
      reg erase_fail_q;
      reg status_write_lock_q;
      reg [2:0] block_guard_q;
      reg [1:0] kind_q;
      reg whole_q;
      reg [`FLSR_TMR_W-1:0] tmr_q;
      reg [3:0] dout_q;
      reg doe_q;
      reg rd_lo_q;
      reg [7:0] snap_q;
      reg prog_go_q;
      reg se_go_q;
      reg be_go_q;
      reg erase_pause_cmd_q;
      reg program_pause_cmd_q;

      reg arm_d;
      reg active_d;
      reg pfail_d;
      reg efail_d;
      reg lock_d;
      reg [2:0] guard_d;
      reg [1:0] kind_d;
      reg whole_d;
      reg [`FLSR_TMR_W-1:0] tmr_d;
      reg prog_go_d;
      reg se_go_d;
      reg be_go_d;
      reg erase_pause_cmd_d;
      reg program_pause_cmd_d;
      reg pset;
      reg eset;
      reg soft_rst;

      wire [3:0] lane = io_s[4*g+3:4*g];
      wire [7:0] stat = {status_write_lock_q, prog_fail_q, erase_fail_q, block_guard_q,
        write_arm_latch_q, operation_active_flag_q};
      wire hw_locked = status_write_lock_q & ~wp_n_s;
      wire errored = prog_fail_q | erase_fail_q;

      always @*
      begin
        arm_d = write_arm_latch_q;
        active_d = operation_active_flag_q;
        pfail_d = prog_fail_q;
        efail_d = erase_fail_q;
        lock_d = status_write_lock_q;
        guard_d = block_guard_q;
        kind_d = kind_q;
        whole_d = whole_q;
        tmr_d = tmr_q;
        prog_go_d = 1'b0;
        se_go_d = 1'b0;
        be_go_d = 1'b0;
        erase_pause_cmd_d = 1'b0;
        program_pause_cmd_d = 1'b0;
        pset = 1'b0;
        eset = 1'b0;
        soft_rst = ~hw_reset_n_s;

        // Completion of the running operation
        case (kind_q)
          K_REG:
          begin
            if (tmr_q == {`FLSR_TMR_W{1'b0}})
            begin
              active_d = 1'b0;
              arm_d = 1'b0;
              kind_d = K_IDLE;
            end
            else
            begin
              tmr_d = tmr_q - {{(`FLSR_TMR_W-1){1'b0}}, 1'b1};
            end
          end
          K_PROG:
          begin
            if (op_done_in[g] && operation_active_flag_q && !errored)
            begin
              if (op_fail_in[g] || op_prot_in[g])
              begin
                pset = 1'b1;
              end
              else
              begin
                active_d = 1'b0;
                arm_d = 1'b0;
                kind_d = K_IDLE;
              end
            end
          end
          K_ERASE:
          begin
            if (op_done_in[g] && operation_active_flag_q && !errored)
            begin
              // Protected sectors skipped by a whole-array erase are no failure
              if (op_fail_in[g] || (op_prot_in[g] && !whole_q))
              begin
                eset = 1'b1;
              end
              else
              begin
                active_d = 1'b0;
                arm_d = 1'b0;
                kind_d = K_IDLE;
              end
            end
          end
          default:
          begin
            kind_d = K_IDLE;
          end
        endcase

        if (exec)
        begin
          case (cmd_q)
            `FLSR_CMD_ARM_WRITE:
            begin
              if (!operation_active_flag_q)
              begin
                arm_d = 1'b1;
              end
            end
            `FLSR_CMD_DISARM_WRITE:
            begin
              if (!operation_active_flag_q)
              begin
                arm_d = 1'b0;
              end
            end
            `FLSR_CMD_CLEAR_STATUS:
            begin
              pfail_d = 1'b0;
              efail_d = 1'b0;
              if (errored)
              begin
                active_d = 1'b0;
                kind_d = K_IDLE;
              end
            end
            `FLSR_CMD_REGISTER_WRITE:
            begin
              // The arm latch is left alone; only guard and lock bits load
              if (may_modify(write_arm_latch_q, operation_active_flag_q) && nbytes >= 4'h2
                && !hw_locked)
              begin
                lock_d = data_q[`FLSR_BIT_WRITE_LOCK];
                guard_d = data_q[`FLSR_BIT_GUARD_HI:`FLSR_BIT_GUARD_LO];
                active_d = 1'b1;
                kind_d = K_REG;
                tmr_d = K_WR_CYC;
              end
            end
            `FLSR_CMD_PAGE_PROGRAM:
            begin
              if (may_modify(write_arm_latch_q, operation_active_flag_q))
              begin
                prog_go_d = 1'b1;
                active_d = 1'b1;
                kind_d = K_PROG;
              end
            end
            `FLSR_CMD_SECTOR_ERASE:
            begin
              if (may_modify(write_arm_latch_q, operation_active_flag_q))
              begin
                se_go_d = 1'b1;
                active_d = 1'b1;
                kind_d = K_ERASE;
                whole_d = 1'b0;
              end
            end
            `FLSR_CMD_WHOLE_ARRAY_ERASE:
            begin
              if (may_modify(write_arm_latch_q, operation_active_flag_q)
                && block_guard_q == 3'h0)
              begin
                be_go_d = 1'b1;
                active_d = 1'b1;
                kind_d = K_ERASE;
                whole_d = 1'b1;
              end
            end
            `FLSR_CMD_ERASE_PAUSE:
            begin
              if (operation_active_flag_q && kind_q == K_ERASE && !errored)
              begin
                erase_pause_cmd_d = 1'b1;
              end
            end
            `FLSR_CMD_PROGRAM_PAUSE:
            begin
              if (operation_active_flag_q && kind_q == K_PROG && !errored)
              begin
                program_pause_cmd_d = 1'b1;
              end
            end
            `FLSR_CMD_SOFT_RESET:
            begin
              soft_rst = 1'b1;
            end
            default:
            begin
              arm_d = arm_d;
            end
          endcase
        end

        // An error reported with a clear in the same cycle survives
        if (pset)
        begin
          pfail_d = 1'b1;
          active_d = 1'b1;
        end
        if (eset)
        begin
          efail_d = 1'b1;
          active_d = 1'b1;
        end

        if (soft_rst)
        begin
          arm_d = 1'b0;
          active_d = 1'b0;
          pfail_d = 1'b0;
          efail_d = 1'b0;
          kind_d = K_IDLE;
          tmr_d = {`FLSR_TMR_W{1'b0}};
          prog_go_d = 1'b0;
          se_go_d = 1'b0;
          be_go_d = 1'b0;
          erase_pause_cmd_d = 1'b0;
          program_pause_cmd_d = 1'b0;
          if (guard_persistence_bit_in)
          begin
            guard_d = `FLSR_RST_GUARD;
          end
        end
      end

      always @(posedge ref_clk_in)
      begin
        if (rst_in)
        begin
          // Power-on: stored bits come back at their shipped state
          hold_q <= 4'h0;
          cmd_q <= 8'h00;
          data_q <= 8'h00;
          write_arm_latch_q <= 1'b0;
          operation_active_flag_q <= 1'b0;
          prog_fail_q <= 1'b0;
          erase_fail_q <= 1'b0;
          status_write_lock_q <= `FLSR_RST_WRITE_LOCK;
          block_guard_q <= `FLSR_RST_GUARD;
          kind_q <= K_IDLE;
          whole_q <= 1'b0;
          tmr_q <= {`FLSR_TMR_W{1'b0}};
          dout_q <= 4'h0;
          doe_q <= 1'b0;
          rd_lo_q <= 1'b0;
          snap_q <= 8'h00;
          prog_go_q <= 1'b0;
          se_go_q <= 1'b0;
          be_go_q <= 1'b0;
          erase_pause_cmd_q <= 1'b0;
          program_pause_cmd_q <= 1'b0;
        end
        else
        begin
          write_arm_latch_q <= arm_d;
          operation_active_flag_q <= active_d;
          prog_fail_q <= pfail_d;
          erase_fail_q <= efail_d;
          status_write_lock_q <= lock_d;
          block_guard_q <= guard_d;
          kind_q <= kind_d;
          whole_q <= whole_d;
          tmr_q <= tmr_d;
          prog_go_q <= prog_go_d;
          se_go_q <= se_go_d;
          be_go_q <= be_go_d;
          erase_pause_cmd_q <= erase_pause_cmd_d;
          program_pause_cmd_q <= program_pause_cmd_d;

          // Each die decodes its own lane
          if (cs_n_s)
          begin
            cmd_q <= 8'h00;
          end
          else if (sck_rise)
          begin
            if (!nib_cnt_q[0])
            begin
              hold_q <= lane;
            end
            else if (nib_cnt_q[4:1] == 4'h0)
            begin
              cmd_q <= {hold_q, lane};
            end
            else if (nib_cnt_q[4:1] == 4'h1)
            begin
              data_q <= {hold_q, lane};
            end
          end

          // Status byte repeats while the frame stays open
          if (cs_n_s)
          begin
            doe_q <= 1'b0;
            rd_lo_q <= 1'b0;
          end
          else if (sck_fall && cmd_q == `FLSR_CMD_READ_STATUS_ONE && nib_cnt_q >= 5'h02)
          begin
            doe_q <= 1'b1;
            rd_lo_q <= ~rd_lo_q;
            if (!rd_lo_q)
            begin
              snap_q <= stat;
              dout_q <= stat[7:4];
            end
            else
            begin
              dout_q <= snap_q[3:0];
            end
          end
        end
      end

      assign io_out[4*g+3:4*g] = dout_q;
      assign io_oe_out[4*g+3:4*g] = {4{doe_q}};
      assign prog_start_out[g] = prog_go_q;
      assign sector_erase_start_out[g] = se_go_q;
      assign whole_erase_start_out[g] = be_go_q;
      assign erase_pause_out[g] = erase_pause_cmd_q;
      assign prog_pause_out[g] = program_pause_cmd_q;
      assign block_guard_out[3*g+2:3*g] = block_guard_q;
      assign status_one_out[8*g+7:8*g] = {status_write_lock_q, prog_fail_q, erase_fail_q,
        block_guard_q, write_arm_latch_q, operation_active_flag_q};
    end
  endgenerate
endmodule

// file: flsr_status_one_assertions.sv
// Purpose: Port checks for the dual-die status register one block
// Assumes: One core clock, synchronous active-high reset
// Notes: Die 0 is watched in depth; die 1 is tied in by lane checks
`timescale 1ns/10ps
module flsr_status_one_assertions (
  input wire ref_clk_in,
  input wire rst_in,
  input wire sck_in,
  input wire cs_n_in,
  input wire [7:0] io_in,
  input wire wp_n_in,
  input wire hw_reset_n_in,
  input wire guard_persistence_bit_in,
  input wire [1:0] op_done_in,
  input wire [1:0] op_fail_in,
  input wire [1:0] op_prot_in,
  input wire [7:0] io_out,
  input wire [7:0] io_oe_out,
  input wire [1:0] prog_start_out,
  input wire [1:0] sector_erase_start_out,
  input wire [1:0] whole_erase_start_out,
  input wire [1:0] erase_pause_out,
  input wire [1:0] prog_pause_out,
  input wire [5:0] block_guard_out,
  input wire [15:0] status_one_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  wire [7:0] s0 = status_one_out[7:0];
  wire arr_start = prog_start_out[0] | sector_erase_start_out[0] | whole_erase_start_out[0];
  reg arr_q;
  // Keeps register-write busy time apart from array operations
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
      arr_q <= 1'b0;
    else if (arr_start)
      arr_q <= 1'b1;
    else if (!s0[0])
      arr_q <= 1'b0;
  end
  sequence s_done_clean;
    op_done_in[0] && !op_fail_in[0] && !op_prot_in[0] && arr_q && s0[0] && s0[6:5] == 2'b00;
  endsequence
  sequence s_ready;
    s0[1:0] == 2'b00;
  endsequence
  a_done_clears: assert property (s_done_clean |=> s_ready)
    else $error("success left arm or active set");
  a_fail_sets: assert property (op_done_in[0] && op_fail_in[0] && arr_q && s0[0] && s0[6:5] == 2'b00 |=> s0[0] && s0[6:5] != 2'b00)
    else $error("failed operation not flagged");
  a_fail_busy: assert property ((s0[6] | s0[5]) |-> s0[0])
    else $error("failure flag without active");
  a_flag_in_op: assert property ($rose(s0[6]) || $rose(s0[5]) |-> $past(s0[0]))
    else $error("failure flag set while idle");
  a_arm_gates: assert property (arr_start |-> $past(s0[1:0]) == 2'b10)
    else $error("array start without arm or while busy");
  a_whole_guard: assert property (whole_erase_start_out[0] |-> $past(s0[4:2]) == 3'b000)
    else $error("whole erase with guard bits set");
  a_pause_busy: assert property ((erase_pause_out[0] | prog_pause_out[0]) |-> $past(s0[0]))
    else $error("pause while idle");
  a_guard_mirror: assert property (block_guard_out == {status_one_out[12:10], s0[4:2]})
    else $error("guard outputs differ from status");
  a_lane_drive: assert property (io_oe_out[0] == io_oe_out[4] && io_oe_out[3:0] == {4{io_oe_out[0]}} && io_oe_out[7:4] == {4{io_oe_out[4]}})
    else $error("lane enables split");
  a_reset_value: assert property ($fell(rst_in) |-> status_one_out == 16'h1C1C)
    else $error("wrong status after reset");
endmodule

bind flsr_status_one flsr_status_one_assertions u_chk (.ref_clk_in, .rst_in, .sck_in, .cs_n_in,
  .io_in, .wp_n_in, .hw_reset_n_in, .guard_persistence_bit_in, .op_done_in, .op_fail_in,
  .op_prot_in, .io_out, .io_oe_out, .prog_start_out, .sector_erase_start_out,
  .whole_erase_start_out, .erase_pause_out, .prog_pause_out, .block_guard_out, .status_one_out);

// file: flsr_host.sv
// Purpose: Host serial controller model driving both four-bit lanes
// Assumes: Mode 0, serial clock period of eight core clocks
// Notes: Samples read nibbles late in the high phase to allow sync delay
`timescale 1ns/10ps
module flsr_host (
  input wire ref_clk_in,
  input wire [7:0] io_out,
  input wire [7:0] io_oe_out,
  output reg sck_out,
  output reg cs_n_out,
  output wire [7:0] io_drv_out
);
  reg [7:0] val_q;
  reg drv_q;
  // A released lane shows the inverse of its last value, never a stale copy
  assign io_drv_out = (io_oe_out & io_out) | (~io_oe_out & (drv_q ? val_q : ~val_q));
  initial
  begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    val_q = 8'h00;
    drv_q = 1'b0;
  end
  task half();
    repeat (4) @(negedge ref_clk_in);
  endtask
  task nib(input [3:0] n);
    val_q = {n, n};
    drv_q = 1'b1;
    half();
    sck_out = 1'b1;
    half();
    sck_out = 1'b0;
  endtask
  task close();
    drv_q = 1'b0;
    half();
    cs_n_out = 1'b1;
    repeat (8) @(negedge ref_clk_in);
  endtask
  task frame(input [7:0] b0, input [7:0] b1, input logic two);
    cs_n_out = 1'b0;
    half();
    nib(b0[7:4]);
    nib(b0[3:0]);
    if (two)
    begin
      nib(b1[7:4]);
      nib(b1[3:0]);
    end
    close();
  endtask
  task read_one(output [15:0] v);
    reg [7:0] h;
    reg [7:0] l;
    cs_n_out = 1'b0;
    half();
    nib(4'h0);
    nib(4'h5);
    drv_q = 1'b0;
    half();
    sck_out = 1'b1;
    half();
    h = io_drv_out;
    sck_out = 1'b0;
    half();
    sck_out = 1'b1;
    half();
    l = io_drv_out;
    sck_out = 1'b0;
    close();
    v = {h[7:4], l[7:4], h[3:0], l[3:0]};
  endtask
endmodule

// file: testbench.sv
// Purpose: Command-level test of status register one on both dies
// Assumes: Both dies always get identical commands
// Notes: Start and pause pulses are tallied and compared at the end
`timescale 1ns/10ps
module testbench;
  reg ref_clk_in = 1'b0;
  reg rst_in = 1'b1;
  reg wp_n_in = 1'b1;
  reg hw_reset_n_in = 1'b1;
  reg guard_persistence_bit_in = 1'b0;
  reg [1:0] op_done_in = 2'h0;
  reg [1:0] op_fail_in = 2'h0;
  reg [1:0] op_prot_in = 2'h0;
  wire sck;
  wire cs_n;
  wire [7:0] io_bus;
  wire [7:0] io_out;
  wire [7:0] io_oe_out;
  wire [9:0] pul;
  wire [5:0] block_guard_out;
  wire [15:0] status_one_out;
  integer n_mismatch = 0;
  integer num_checks = 0;
  integer cyc = 0;
  reg [2:0] cnt [0:4];
  integer i;
  always #10 ref_clk_in = ~ref_clk_in;
  flsr_host host (.ref_clk_in(ref_clk_in), .io_out(io_out), .io_oe_out(io_oe_out),
    .sck_out(sck), .cs_n_out(cs_n), .io_drv_out(io_bus));
  flsr_status_one dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .sck_in(sck), .cs_n_in(cs_n),
    .io_in(io_bus), .wp_n_in(wp_n_in), .hw_reset_n_in(hw_reset_n_in),
    .guard_persistence_bit_in(guard_persistence_bit_in), .op_done_in(op_done_in),
    .op_fail_in(op_fail_in), .op_prot_in(op_prot_in), .io_out(io_out), .io_oe_out(io_oe_out),
    .prog_start_out(pul[9:8]), .sector_erase_start_out(pul[7:6]),
    .whole_erase_start_out(pul[5:4]), .erase_pause_out(pul[3:2]), .prog_pause_out(pul[1:0]),
    .block_guard_out(block_guard_out), .status_one_out(status_one_out));
  initial
    for (i = 0; i < 5; i = i + 1)
      cnt[i] = 3'h0;
  always @(posedge ref_clk_in)
  begin
    cyc <= cyc + 1;
    for (int k = 0; k < 5; k = k + 1)
      if (pul[8 - 2 * k +: 2] == 2'b11)
        cnt[k] <= cnt[k] + 3'h1;
    if (cyc == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      end_of_test();
    end
  end
  task end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input [15:0] seen, input [15:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task rd(input [7:0] e);
    reg [15:0] v;
    host.read_one(v);
    chk(v, {e, e});
  endtask
  task cmd(input [7:0] c);
    host.frame(c, 8'h00, 1'b0);
  endtask
  task register_write_cmd(input [7:0] d);
    host.frame(8'h01, d, 1'b1);
  endtask
  task wt();
    repeat (150) @(negedge ref_clk_in);
  endtask
  task done(input logic f, input logic p);
    @(negedge ref_clk_in);
    op_done_in = 2'h3;
    op_fail_in = {f, f};
    op_prot_in = {p, p};
    @(negedge ref_clk_in);
    op_done_in = 2'h0;
    op_fail_in = 2'h0;
    op_prot_in = 2'h0;
    repeat (4) @(negedge ref_clk_in);
  endtask
  initial
  begin
    repeat (16) @(negedge ref_clk_in);
    rst_in = 1'b0;
    repeat (6) @(negedge ref_clk_in);
    rd(8'h1C);
    chk({10'h000, block_guard_out}, 16'h003F);
    register_write_cmd(8'h00);
    wt();
    rd(8'h1C);
    cmd(8'h06);
    rd(8'h1E);
    cmd(8'h04);
    rd(8'h1C);
    cmd(8'h06);
    register_write_cmd(8'h00);
    rd(8'h03);
    wt();
    rd(8'h00);
    // Disarm and erase pause must bounce off a running program
    cmd(8'h06);
    cmd(8'h02);
    cmd(8'h04);
    cmd(8'h75);
    rd(8'h03);
    done(1'b0, 1'b0);
    rd(8'h00);
    cmd(8'h06);
    cmd(8'h02);
    done(1'b1, 1'b0);
    register_write_cmd(8'h00);
    rd(8'h43);
    cmd(8'h30);
    rd(8'h02);
    cmd(8'h04);
    rd(8'h00);
    cmd(8'h06);
    cmd(8'hD8);
    done(1'b0, 1'b1);
    rd(8'h23);
    cmd(8'h30);
    cmd(8'h04);
    cmd(8'h06);
    cmd(8'h60);
    done(1'b0, 1'b1);
    rd(8'h00);
    cmd(8'h06);
    cmd(8'hD8);
    cmd(8'h85);
    cmd(8'h75);
    cmd(8'hF0);
    rd(8'h00);
    cmd(8'h06);
    register_write_cmd(8'h04);
    wt();
    cmd(8'h06);
    cmd(8'h60);
    rd(8'h06);
    register_write_cmd(8'h84);
    wt();
    rd(8'h84);
    wp_n_in = 1'b0;
    cmd(8'h06);
    register_write_cmd(8'h00);
    wt();
    rd(8'h86);
    wp_n_in = 1'b1;
    register_write_cmd(8'h00);
    wt();
    rd(8'h00);
    guard_persistence_bit_in = 1'b1;
    cmd(8'h06);
    hw_reset_n_in = 1'b0;
    repeat (8) @(negedge ref_clk_in);
    hw_reset_n_in = 1'b1;
    repeat (8) @(negedge ref_clk_in);
    rd(8'h1C);
    chk({cnt[0], cnt[1], cnt[2], cnt[3], cnt[4], 1'b0}, 16'h4890);
    end_of_test();
  end
endmodule
